// >>> shared/ssm_pkg.sv
// Constants, register map and types shared by the synchronous serial block.
package ssm_pkg;

  localparam int unsigned CHAR_BITS = 8;
  localparam logic [3:0]  EDGE_LAST = 4'hf;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [15:0] IDX_STATUS = 16'h4320;
  localparam logic [15:0] IDX_TXD    = 16'h4322;
  localparam logic [15:0] IDX_RXD    = 16'h4324;
  localparam logic [15:0] IDX_CTRL   = 16'h4326;

  localparam int unsigned CTL_EN   = 0;
  localparam int unsigned CTL_ROLE = 1;
  localparam int unsigned CTL_POL  = 2;
  localparam int unsigned CTL_PHA  = 3;
  localparam int unsigned CTL_TXIE = 4;
  localparam int unsigned CTL_RXIE = 5;
  localparam int unsigned CTL_BITS = 6;

  localparam int unsigned ST_TXE = 0;
  localparam int unsigned ST_RXF = 1;
  localparam int unsigned ST_BSY = 2;

  localparam logic [5:0]  CTRL_RESET  = 6'h00;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [31:0] WORD_RESET  = 32'h0000_0000;
  localparam logic [3:0]  COUNT_RESET = 4'h0;

  typedef enum logic [1:0]
  {
    SSM_IDLE = 2'b01,
    SSM_XFER = 2'b10
  } ssm_state_t;

  function automatic logic [31:0] byteAddr(input logic [15:0] idx);
    return {14'h0000, idx, 2'b00};
  endfunction : byteAddr

endpackage : ssm_pkg

// >>> src/ssm_pin_sync.sv
// Two-stage synchroniser for one pin with edge detection after the second stage.
`timescale 1ns/100ps
module ssm_pin_sync (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic pinIn,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_reg;
  logic meta_next;
  logic stable_reg;
  logic stable_next;
  logic prev_reg;
  logic prev_next;

  always_comb
  begin
    meta_next   = pinIn;
    stable_next = meta_reg;
    prev_next   = stable_reg;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      meta_reg   <= 1'b0;
      stable_reg <= 1'b0;
      prev_reg   <= 1'b0;
    end
    else
    begin
      meta_reg   <= meta_next;
      stable_reg <= stable_next;
      prev_reg   <= prev_next;
    end
  end

  assign level = stable_reg;
  assign rise  = stable_reg & ~prev_reg;
  assign fall  = ~stable_reg & prev_reg;

endmodule : ssm_pin_sync

// >>> src/ssm_top.sv
// Synchronous serial master/slave with one-byte buffers and an APB register slave.
//
// Overview of operation
// - Characters are always eight bits long in both roles.
// - Role bit 1 selects master, 0 selects slave, slave after reset.
// - Master shift clock toggles on each timer underflow during a transfer and drives the clock pin.
// - Slave clock is synchronised to the system clock and its edges detected there.
// - Polarity bit 1 makes the clock active low, 0 active high by default.
// - Phase with polarity picks one of four edge timings for shift and sample.
// - Enabling makes the block ready and enables clock input or output.
// - Writing transmit data loads the buffer and, in master role, starts a transfer.
// - Transmit bits leave most significant first, one per shift edge.
// - Transmit empty drops on write, rises when the byte enters the shifter.
// - A write while the buffer is full replaces the waiting byte.
// - Master busy rises when a byte is loaded, falls when it completes.
// - Slave busy follows the slave select input.
// - Slave responds only while slave select is low.
// - Clock pin is driven in master role and an input in slave role.
// - Eight received bits go to the receive buffer; reading clears full.
// - Transmit and receive run together; master receives only after a write.
// - Disabling empties both buffers.
// - Transmit empty and receive full share one gated interrupt pulse.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
module ssm_top (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timerUnderflow,
  input  wire logic        serialDataIn,
  input  wire logic        serialClockIn,
  input  wire logic        slaveSelectN,
  output logic             serialDataOut,
  output logic             serialClockOut,
  output logic             serialClockOe,
  output logic             irqPulse
);

  logic [5:0]          ctrl_reg;
  logic [5:0]          ctrl_next;
  logic [7:0]          txBuf_reg;
  logic [7:0]          txBuf_next;
  logic                txEmpty_reg;
  logic                txEmpty_next;
  logic [7:0]          rxBuf_reg;
  logic [7:0]          rxBuf_next;
  logic                rxFull_reg;
  logic                rxFull_next;
  logic [7:0]          txShift_reg;
  logic [7:0]          txShift_next;
  logic [7:0]          rxShift_reg;
  logic [7:0]          rxShift_next;
  logic [3:0]          edgeCnt_reg;
  logic [3:0]          edgeCnt_next;
  ssm_pkg::ssm_state_t state_reg;
  ssm_pkg::ssm_state_t state_next;
  logic                sck_reg;
  logic                sck_next;
  logic                sckOe_reg;
  logic                sckOe_next;
  logic                sdo_reg;
  logic                sdo_next;
  logic                busy_reg;
  logic                busy_next;
  logic                irq_reg;
  logic                irq_next;
  logic [31:0]         prdata_reg;
  logic [31:0]         prdata_next;
  logic                pready_reg;
  logic                pready_next;
  logic                pslverr_reg;
  logic                pslverr_next;

  logic sdiLvl;
  logic sckLvl;
  logic sckRise;
  logic sckFall;
  logic ssnLvl;

  logic en;
  logic master;
  logic pol;
  logic pha;
  logic busWait;
  logic access;
  logic hitStatus;
  logic hitTxd;
  logic hitRxd;
  logic hitCtrl;
  logic tick;
  logic lead;
  logic trail;
  logic edgeEv;
  logic sampleEv;
  logic shiftEv;
  logic slaveSel;

  // The slave clock is at most a third of the system clock, so edges are not missed.
  ssm_pin_sync u_sck_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pinIn   (serialClockIn),
    .level   (sckLvl),
    .rise    (sckRise),
    .fall    (sckFall)
  );

  ssm_pin_sync u_ssn_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pinIn   (slaveSelectN),
    .level   (ssnLvl),
    .rise    (),
    .fall    ()
  );

  ssm_pin_sync u_sdi_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pinIn   (serialDataIn),
    .level   (sdiLvl),
    .rise    (),
    .fall    ()
  );

  assign en     = ctrl_reg[ssm_pkg::CTL_EN];
  assign master = ctrl_reg[ssm_pkg::CTL_ROLE];
  assign pol    = ctrl_reg[ssm_pkg::CTL_POL];
  assign pha    = ctrl_reg[ssm_pkg::CTL_PHA];

  always_comb
  begin
    ctrl_next    = ctrl_reg;
    txBuf_next   = txBuf_reg;
    txEmpty_next = txEmpty_reg;
    rxBuf_next   = rxBuf_reg;
    rxFull_next  = rxFull_reg;
    txShift_next = txShift_reg;
    rxShift_next = rxShift_reg;
    edgeCnt_next = edgeCnt_reg;
    state_next   = state_reg;
    sck_next     = sck_reg;
    sdo_next     = sdo_reg;
    irq_next     = 1'b0;

    busWait      = psel & penable & ~pready_reg;
    access       = psel & penable & pready_reg;
    hitStatus    = paddr == ssm_pkg::byteAddr(ssm_pkg::IDX_STATUS);
    hitTxd       = paddr == ssm_pkg::byteAddr(ssm_pkg::IDX_TXD);
    hitRxd       = paddr == ssm_pkg::byteAddr(ssm_pkg::IDX_RXD);
    hitCtrl      = paddr == ssm_pkg::byteAddr(ssm_pkg::IDX_CTRL);
    pready_next  = busWait;
    pslverr_next = busWait & ~(hitStatus | hitTxd | hitRxd | hitCtrl);
    prdata_next  = busWait ? ssm_pkg::WORD_RESET : prdata_reg;
    if (busWait & ~pwrite)
    begin
      prdata_next = ssm_pkg::WORD_RESET;
      if (hitStatus)
      begin
        prdata_next[ssm_pkg::ST_TXE] = txEmpty_reg;
        prdata_next[ssm_pkg::ST_RXF] = rxFull_reg;
        prdata_next[ssm_pkg::ST_BSY] = busy_reg;
      end
      if (hitTxd)
        prdata_next[7:0] = txBuf_reg;
      if (hitRxd)
        prdata_next[7:0] = rxBuf_reg;
      if (hitCtrl)
        prdata_next[5:0] = ctrl_reg;
    end
    if (access & ~pwrite & hitRxd)
      rxFull_next = 1'b0;

    // Master edges come from timer underflows; slave edges from the synchronised pin.
    tick     = en & master & (state_reg == ssm_pkg::SSM_XFER) & timerUnderflow;
    slaveSel = en & ~master & ~ssnLvl;
    if (master)
    begin
      lead  = tick & (sck_reg == pol);
      trail = tick & (sck_reg != pol);
    end
    else
    begin
      lead  = slaveSel & (pol ? sckFall : sckRise);
      trail = slaveSel & (pol ? sckRise : sckFall);
    end
    edgeEv   = lead | trail;
    sampleEv = pha ? trail : lead;
    shiftEv  = pha ? lead : trail;

    if (tick)
      sck_next = ~sck_reg;
    if (sampleEv)
      rxShift_next = {rxShift_reg[6:0], sdiLvl};
    if (shiftEv)
    begin
      sdo_next     = txShift_reg[7];
      txShift_next = {txShift_reg[6:0], 1'b0};
    end
    if (edgeEv)
    begin
      state_next   = ssm_pkg::SSM_XFER;
      edgeCnt_next = edgeCnt_reg + 4'h1;
      if (edgeCnt_reg == ssm_pkg::EDGE_LAST)
      begin
        // Sixteen edges make one fixed eight-bit character.
        state_next  = ssm_pkg::SSM_IDLE;
        rxBuf_next  = rxShift_next;
        rxFull_next = 1'b1;
        irq_next    = ctrl_reg[ssm_pkg::CTL_RXIE];
      end
    end
    if (~master & ssnLvl)
    begin
      edgeCnt_next = ssm_pkg::COUNT_RESET;
      state_next   = ssm_pkg::SSM_IDLE;
    end

    // A waiting byte enters the shifter between characters.
    if (en & (state_reg == ssm_pkg::SSM_IDLE) & ~edgeEv & ~txEmpty_reg)
    begin
      txShift_next = pha ? txBuf_reg : {txBuf_reg[6:0], 1'b0};
      if (~pha)
        sdo_next = txBuf_reg[7];
      txEmpty_next = 1'b1;
      irq_next     = ctrl_reg[ssm_pkg::CTL_TXIE];
      if (master)
        state_next = ssm_pkg::SSM_XFER;
    end
    if (master & (state_reg == ssm_pkg::SSM_IDLE))
      sck_next = pol;

    if (access & pwrite & hitTxd & en)
    begin
      txBuf_next   = pwdata[7:0];
      txEmpty_next = 1'b0;
    end

    if (~en)
    begin
      txEmpty_next = 1'b1;
      rxFull_next  = 1'b0;
      state_next   = ssm_pkg::SSM_IDLE;
      edgeCnt_next = ssm_pkg::COUNT_RESET;
      sck_next     = pol;
    end
    if (access & pwrite & hitCtrl)
      ctrl_next = pwdata[ssm_pkg::CTL_BITS-1:0];

    sckOe_next = en & master;
    if (master)
      busy_next = state_next == ssm_pkg::SSM_XFER;
    else
      busy_next = en & ~ssnLvl;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ctrl_reg    <= ssm_pkg::CTRL_RESET;
      txBuf_reg   <= ssm_pkg::BYTE_RESET;
      txEmpty_reg <= 1'b1;
      rxBuf_reg   <= ssm_pkg::BYTE_RESET;
      rxFull_reg  <= 1'b0;
      txShift_reg <= ssm_pkg::BYTE_RESET;
      rxShift_reg <= ssm_pkg::BYTE_RESET;
      edgeCnt_reg <= ssm_pkg::COUNT_RESET;
      state_reg   <= ssm_pkg::SSM_IDLE;
      sck_reg     <= 1'b0;
      sckOe_reg   <= 1'b0;
      sdo_reg     <= 1'b0;
      busy_reg    <= 1'b0;
      irq_reg     <= 1'b0;
      prdata_reg  <= ssm_pkg::WORD_RESET;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg    <= ctrl_next;
      txBuf_reg   <= txBuf_next;
      txEmpty_reg <= txEmpty_next;
      rxBuf_reg   <= rxBuf_next;
      rxFull_reg  <= rxFull_next;
      txShift_reg <= txShift_next;
      rxShift_reg <= rxShift_next;
      edgeCnt_reg <= edgeCnt_next;
      state_reg   <= state_next;
      sck_reg     <= sck_next;
      sckOe_reg   <= sckOe_next;
      sdo_reg     <= sdo_next;
      busy_reg    <= busy_next;
      irq_reg     <= irq_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pslverr_reg;
  assign serialDataOut  = sdo_reg;
  assign serialClockOut = sck_reg;
  assign serialClockOe  = sckOe_reg;
  assign irqPulse       = irq_reg;

endmodule : ssm_top

// >>> tb/ssm_checker.sv
// Port-level assertions for the synchronous serial block.
`timescale 1ns/100ps
module ssm_checker (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timerUnderflow,
  input wire logic        serialClockOut,
  input wire logic        serialClockOe,
  input wire logic        irqPulse
);
  wire wr = psel && pwrite && pready;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held too long");
  property p_lat; psel && $rose(penable) |=> pready; endproperty
  a_lat: assert property (p_lat) else $error("pready not in second access cycle");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("pready outside access phase");
  property p_idle; !psel |=> !pready; endproperty
  a_idle: assert property (p_idle) else $error("pready without select");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error answer malformed");
  property p_rst; disable iff (1'h0) sys_rst |=> !pready && !irqPulse && !serialClockOe;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  property p_sck;
    $changed(serialClockOut) |-> $past(timerUnderflow) || $past(wr) || $past(wr, 2);
  endproperty
  a_sck: assert property (p_sck) else $error("clock moved without underflow");
  property p_oe; $changed(serialClockOe) |-> $past(wr) || $past(wr, 2); endproperty
  a_oe: assert property (p_oe) else $error("clock enable moved without write");
endmodule : ssm_checker

bind ssm_top ssm_checker ssm_checker_i (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .timerUnderflow(timerUnderflow),
  .serialClockOut(serialClockOut), .serialClockOe(serialClockOe), .irqPulse(irqPulse)
);

// >>> tb/ssm_slave_model.sv
// Behavioural far-side serial device that shifts a byte each character.
`timescale 1ns/100ps
module ssm_slave_model (
  input  wire logic       sys_clk,
  input  wire logic       pinClk,
  input  wire logic       pinOut,
  input  wire logic       pol,
  input  wire logic       pha,
  input  wire logic       start,
  input  wire logic [7:0] txByte,
  output logic            pinIn,
  output logic      [7:0] rxByte
);
  logic       clkLast = 1'h0;
  logic [7:0] sh = 8'h00;
  int         n = 0;
  initial
  begin
    pinIn = 1'h0;
    rxByte = 8'h00;
  end
  // Between characters the data line holds the last bit sent, or the next byte's first bit when pha is 0.
  always @(posedge sys_clk)
  begin
    clkLast <= pinClk;
    if (start)
    begin
      n <= 0;
      if (pha)
        sh <= txByte;
      else
        {pinIn, sh} <= {txByte, 1'h0};
    end
    else if (pinClk != clkLast)
    begin
      if ((pinClk != pol) != pha)
      begin
        rxByte <= {rxByte[6:0], pinOut};
        n <= (pha && n == 7) ? 0 : n + 1;
        if (pha && n == 7)
          sh <= txByte;
      end
      else if (!pha && n == 8)
      begin
        {pinIn, sh} <= {txByte, ~pinIn};
        n <= 0;
      end
      else
        {pinIn, sh} <= {sh, ~pinIn};
    end
  end
endmodule : ssm_slave_model

// >>> tb/ssm_top_test.sv
// Self-checking bench for the synchronous serial block.
`timescale 1ns/100ps
module ssm_top_test;
  logic        sys_clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdat, lfsr = 32'hc456;
  logic        pready, pslverr, rerr, serialDataOut, serialClockOut, serialClockOe, irqPulse;
  logic        timerUnderflow = 1'h0, serialClockIn = 1'h0, slaveSelectN = 1'h1;
  logic        start = 1'h0, pol = 1'h0, pha = 1'h0, serialDataIn;
  logic [7:0]  pByte = 8'h00, rxByte, tx;
  logic [7:0]  sent[$];
  int          miscompares = 0, n_compared = 0, irqs = 0, base;
  wire         pinClk = serialClockOe ? serialClockOut : serialClockIn;
  ssm_top ssm_top_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timerUnderflow(timerUnderflow), .serialDataIn(serialDataIn), .serialClockIn(pinClk),
    .slaveSelectN(slaveSelectN), .serialDataOut(serialDataOut),
    .serialClockOut(serialClockOut), .serialClockOe(serialClockOe), .irqPulse(irqPulse)
  );
  ssm_slave_model ssm_slave_model_i (
    .sys_clk(sys_clk), .pinClk(pinClk), .pinOut(serialDataOut), .pol(pol), .pha(pha),
    .start(start), .txByte(pByte), .pinIn(serialDataIn), .rxByte(rxByte)
  );
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (irqPulse === 1'h1)
      irqs <= irqs + 1;
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step
  task automatic results();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {14'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do
      @(posedge sys_clk);
    while (pready !== 1'h1 && ++k < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
    if (k == 20)
    begin
      miscompares++;
      results();
    end
  endtask : apb
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'h0, idx, 32'h0);
    chk(rdat, exp);
  endtask : rd
  task automatic ticks(input int n, input logic master);
    repeat (2 * n)
    begin
      if (master)
        timerUnderflow <= 1'h1;
      else
        serialClockIn <= ~serialClockIn;
      @(posedge sys_clk);
      timerUnderflow <= 1'h0;
      repeat (4) @(posedge sys_clk);
    end
  endtask : ticks
  task automatic kick();
    lfsr = step(lfsr);
    pByte <= lfsr[7:0];
    tx = lfsr[15:8];
    start <= 1'h1;
    @(posedge sys_clk);
    start <= 1'h0;
  endtask : kick
  initial
  begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(posedge sys_clk);
    rd(ssm_pkg::IDX_STATUS, 32'h1);
    rd(ssm_pkg::IDX_CTRL, 32'h0);
    apb(1'h0, 16'h4328, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    $display("register test done");
    for (int m = 0; m < 4; m++)
    begin
      pol <= m[0];
      pha <= m[1];
      apb(1'h1, ssm_pkg::IDX_CTRL, 32'(32'h33 | (m << 2)));
      repeat (4) @(posedge sys_clk);
      rd(ssm_pkg::IDX_CTRL, 32'(32'h33 | (m << 2)));
      kick();
      base = irqs;
      sent.push_back(tx);
      apb(1'h1, ssm_pkg::IDX_TXD, {24'h0, tx});
      rd(ssm_pkg::IDX_STATUS, 32'h5);
      chk({31'h0, serialClockOe}, 32'h1);
      chk(32'(irqs - base), 32'h1);
      apb(1'h1, ssm_pkg::IDX_TXD, {24'h0, ~tx});
      sent.push_back(tx ^ 8'h3c);
      apb(1'h1, ssm_pkg::IDX_TXD, {24'h0, tx ^ 8'h3c});
      rd(ssm_pkg::IDX_STATUS, 32'h4);
      rd(ssm_pkg::IDX_TXD, {24'h0, tx ^ 8'h3c});
      ticks(8, 1'h1);
      rd(ssm_pkg::IDX_STATUS, 32'h7);
      chk({24'h0, rxByte}, {24'h0, sent.pop_front()});
      rd(ssm_pkg::IDX_RXD, {24'h0, pByte});
      ticks(8, 1'h1);
      rd(ssm_pkg::IDX_STATUS, 32'h3);
      chk({24'h0, rxByte}, {24'h0, sent.pop_front()});
      apb(1'h1, ssm_pkg::IDX_CTRL, 32'h0);
      apb(1'h1, ssm_pkg::IDX_TXD, {24'h0, tx});
      rd(ssm_pkg::IDX_STATUS, 32'h1);
    end
    $display("master tests done");
    pol <= 1'h0;
    pha <= 1'h0;
    apb(1'h1, ssm_pkg::IDX_CTRL, 32'h1);
    ticks(3, 1'h0);
    rd(ssm_pkg::IDX_STATUS, 32'h1);
    slaveSelectN <= 1'h0;
    repeat (4) @(posedge sys_clk);
    ticks(3, 1'h0);
    rd(ssm_pkg::IDX_STATUS, 32'h5);
    slaveSelectN <= 1'h1;
    repeat (4) @(posedge sys_clk);
    kick();
    rd(ssm_pkg::IDX_STATUS, 32'h1);
    slaveSelectN <= 1'h0;
    repeat (4) @(posedge sys_clk);
    ticks(8, 1'h0);
    rd(ssm_pkg::IDX_STATUS, 32'h7);
    rd(ssm_pkg::IDX_RXD, {24'h0, pByte});
    $display("slave test done");
    results();
  end
endmodule : ssm_top_test
